// ==== rtl/lso_defs.vh ====
// Constants for the limit switch output logic
`ifndef LSO_DEFS_VH
`define LSO_DEFS_VH
// =====================================================
// Function selector codes
`define LSO_FUNC_OFF 3'h0
`define LSO_FUNC_ON 3'h1
`define LSO_FUNC_DIAG 3'h2
`define LSO_FUNC_LIMIT 3'h3
`define LSO_FUNC_DOUT 3'h4
// =====================================================
// Diagnostic category codes
`define LSO_DIAG_ALARM 2'h0
`define LSO_DIAG_ALARM_WARN 2'h1
`define LSO_DIAG_WARN 2'h2
// =====================================================
// Digital output source codes
`define LSO_DSRC_OFF 2'h0
`define LSO_DSRC_AD1 2'h1
`define LSO_DSRC_AD2 2'h2
// =====================================================
// Failure mode codes
`define LSO_FAIL_ACTUAL 2'h0
`define LSO_FAIL_OPEN 2'h1
`define LSO_FAIL_CLOSED 2'h2
// =====================================================
// Process variable select: 0 is off
`define LSO_PV_OFF 4'h0
`define LSO_PV_COUNT 11
// =====================================================
// Reset values
`define LSO_THRESH_RST 32'h00000000
// =====================================================
// Timing: delay in tenths of a second
`define LSO_DELAY_MAX_DS 1000
// Clock cycles in one tenth of a second at 250 MHz, kept integer
`define LSO_TICK_CYCLES 25000000
`endif

// ==== rtl/lso_fcmp.v ====
// Signed IEEE-754 single compare: a greater than b
`timescale 1ns/1ps
module lso_fcmp (
  input wire [31:0] a,
  input wire [31:0] b,
  output reg gt
);
  // =====================================================
  // Map float to an order-preserving unsigned key
  function [31:0] lso_key;
    input [31:0] f;
    begin
      if (f[31]) begin
        lso_key = ~f;
      end else begin
        lso_key = f | 32'h80000000;
      end
      // Treat negative zero as positive zero
      if (f[30:0] == 31'h00000000) begin
        lso_key = 32'h80000000;
      end
    end
  endfunction

  // Comparison of the two keys
  always @* begin
    gt = lso_key(a) > lso_key(b);
  end
endmodule

// ==== rtl/lso_switch.v ====
// Switch output decision logic with limit hysteresis and delays
`timescale 1ns/1ps
`include "lso_defs.vh"
module lso_switch #(
  parameter PV_COUNT = `LSO_PV_COUNT,
  parameter TICK_CYCLES = `LSO_TICK_CYCLES,
  parameter DELAY_MAX = `LSO_DELAY_MAX_DS
) (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] func_sel,
  input wire [3:0] pv_sel,
  input wire [32*PV_COUNT-1:0] pv_values,
  input wire [31:0] thresh_on,
  input wire [31:0] thresh_off,
  input wire [9:0] delay_on_ds,
  input wire [9:0] delay_off_ds,
  input wire [1:0] diag_cat,
  input wire alarm_active,
  input wire warning_active,
  input wire [1:0] dout_src,
  input wire adv_diag1_sw,
  input wire adv_diag2_sw,
  input wire [1:0] fail_mode,
  input wire invert,
  output reg switch_closed,
  output reg switch_status
);
  // =====================================================
  // Settings registers (factory defaults on reset)
  reg [2:0] func_q;
  reg [3:0] pv_q;
  reg [31:0] on_q;
  reg [31:0] off_q;
  reg [9:0] don_q;
  reg [9:0] doff_q;
  reg [1:0] cat_q;
  reg [1:0] src_q;
  reg [1:0] fail_q;
  reg inv_q;

  // =====================================================
  // Clamp a delay setting to the settable range
  function [9:0] lso_clamp;
    input [9:0] d;
    begin
      if (d > DELAY_MAX) begin
        lso_clamp = DELAY_MAX[9:0];
      end else begin
        lso_clamp = d;
      end
    end
  endfunction

  // Settings capture; threshold factory value is zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      func_q <= `LSO_FUNC_OFF;
      pv_q <= `LSO_PV_OFF;
      on_q <= `LSO_THRESH_RST;
      off_q <= `LSO_THRESH_RST;
      don_q <= 10'h000;
      doff_q <= 10'h000;
      cat_q <= `LSO_DIAG_ALARM;
      src_q <= `LSO_DSRC_OFF;
      fail_q <= `LSO_FAIL_OPEN;
      inv_q <= 1'b0;
    end else begin
      func_q <= func_sel;
      pv_q <= (pv_sel > PV_COUNT) ? `LSO_PV_OFF : pv_sel;
      on_q <= thresh_on;
      off_q <= thresh_off;
      // Clamp delays to the settable range
      don_q <= lso_clamp(delay_on_ds);
      doff_q <= lso_clamp(delay_off_ds);
      cat_q <= diag_cat;
      src_q <= dout_src;
      fail_q <= fail_mode;
      inv_q <= invert;
    end
  end

  // =====================================================
  // Monitored value mux
  reg [31:0] pv_val;
  integer i;
  always @* begin
    pv_val = 32'h00000000;
    for (i = 0; i < PV_COUNT; i = i + 1) begin
      if (pv_q == i + 1) begin
        pv_val = pv_values[32*i +: 32];
      end
    end
  end

  // Comparators
  wire val_gt_on;
  wire on_gt_val;
  wire val_gt_off;
  wire off_gt_val;
  wire on_gt_off;
  lso_fcmp u_c0 (.a(pv_val), .b(on_q), .gt(val_gt_on));
  lso_fcmp u_c1 (.a(on_q), .b(pv_val), .gt(on_gt_val));
  lso_fcmp u_c2 (.a(pv_val), .b(off_q), .gt(val_gt_off));
  lso_fcmp u_c3 (.a(off_q), .b(pv_val), .gt(off_gt_val));
  lso_fcmp u_c4 (.a(on_q), .b(off_q), .gt(on_gt_off));

  // Raw limit requests, before delay
  reg want_close;
  reg want_open;
  always @* begin
    if (on_gt_off) begin
      want_close = val_gt_on;
      want_open = off_gt_val;
    end else begin
      want_close = on_gt_val;
      want_open = val_gt_off;
    end
  end

  // =====================================================
  // Tenth-second tick divider
  localparam TICK_N = (TICK_CYCLES < 1) ? 1 : TICK_CYCLES;
  reg [31:0] div_q;
  reg tick_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q >= TICK_N - 1) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // =====================================================
  // Limit state with switch-on and switch-off delays
  reg lim_q;
  reg [9:0] dly_q;
  wire lim_en = (func_q == `LSO_FUNC_LIMIT) && (pv_q != `LSO_PV_OFF);
  wire req_change = lim_q ? (want_open && !want_close) : want_close;
  wire [9:0] dly_target = lim_q ? doff_q : don_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lim_q <= 1'b0;
      dly_q <= 10'h000;
    end else if (!lim_en) begin
      // Off choice disables monitoring
      lim_q <= 1'b0;
      dly_q <= 10'h000;
    end else if (!req_change) begin
      // Between thresholds hold state
      dly_q <= 10'h000;
    end else if (dly_q >= dly_target) begin
      lim_q <= ~lim_q;
      dly_q <= 10'h000;
    end else if (tick_q) begin
      dly_q <= dly_q + 10'h001;
    end
  end

  // =====================================================
  // Mode selection, failure mode and inversion
  reg diag_evt;
  reg base;
  reg eff;
  always @* begin
    case (cat_q)
      `LSO_DIAG_ALARM: diag_evt = alarm_active;
      `LSO_DIAG_WARN: diag_evt = warning_active;
      `LSO_DIAG_ALARM_WARN: diag_evt = alarm_active | warning_active;
      default: diag_evt = alarm_active;
    endcase
    case (func_q)
      `LSO_FUNC_OFF: base = 1'b0;
      `LSO_FUNC_ON: base = 1'b1;
      `LSO_FUNC_DIAG: base = ~diag_evt;
      `LSO_FUNC_LIMIT: base = lim_q;
      `LSO_FUNC_DOUT: begin
        case (src_q)
          `LSO_DSRC_AD1: base = adv_diag1_sw;
          `LSO_DSRC_AD2: base = adv_diag2_sw;
          default: base = 1'b0;
        endcase
      end
      default: base = 1'b0;
    endcase
    eff = base;
    if (alarm_active) begin
      case (fail_q)
        `LSO_FAIL_OPEN: eff = 1'b0;
        `LSO_FAIL_CLOSED: eff = 1'b1;
        default: eff = base;
      endcase
    end
  end

  // Output register; status mirrors the driven state
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switch_closed <= 1'b0;
      switch_status <= 1'b0;
    end else begin
      switch_closed <= eff ^ inv_q;
      switch_status <= eff ^ inv_q;
    end
  end
endmodule

// ==== tb/lso_sense.sv ====
// Model of the external circuit that senses switch conduction
`timescale 1ns/1ps
module lso_sense (
  input wire ref_clk,
  input wire rst,
  input wire switch_closed,
  output reg sensed
);
  // Sense line follows the conduction state one clock later
  always @(posedge ref_clk or posedge rst) begin
    if (rst) sensed <= 1'b0;
    else sensed <= switch_closed;
  end
endmodule

// ==== tb/lso_switch_properties.sv ====
// Checker for the switch output decision logic
`timescale 1ns/1ps
`include "lso_defs.vh"
module lso_switch_properties (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] func_sel,
  input wire [3:0] pv_sel,
  input wire [1:0] diag_cat,
  input wire alarm_active,
  input wire [1:0] dout_src,
  input wire adv_diag1_sw,
  input wire [1:0] fail_mode,
  input wire invert,
  input wire switch_closed,
  input wire switch_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // No alarm override and no inversion
  wire q = !alarm_active && !invert;
  // =====================================================
  // Output relations
  AST_STATUS: assert property (switch_status == switch_closed)
    else $error("status differs from output");
  AST_OFF: assert property ((func_sel == `LSO_FUNC_OFF && q) [*2] |=> !switch_closed)
    else $error("off mode conducts");
  AST_ON: assert property ((func_sel == `LSO_FUNC_ON && q) [*2] |=> switch_closed)
    else $error("on mode open");
  AST_INV: assert property ((func_sel == `LSO_FUNC_ON && !alarm_active && invert) [*2] |=> !switch_closed)
    else $error("inverted on mode conducts");
  AST_FAIL_OPEN: assert property ((alarm_active && fail_mode == `LSO_FAIL_OPEN && !invert) [*2] |=> !switch_closed)
    else $error("alarm open mode conducts");
  AST_FAIL_CLOSED: assert property ((alarm_active && fail_mode == `LSO_FAIL_CLOSED && !invert) [*2] |=> switch_closed)
    else $error("alarm closed mode open");
  AST_DIAG: assert property ((func_sel == `LSO_FUNC_DIAG && diag_cat == `LSO_DIAG_ALARM && q) [*2] |=> switch_closed)
    else $error("diagnostic mode open without alarm");
  AST_DOUT: assert property ((func_sel == `LSO_FUNC_DOUT && dout_src == `LSO_DSRC_AD1 && adv_diag1_sw && q) [*2] |=> switch_closed)
    else $error("digital mode ignores block one");
  AST_PV_OFF: assert property ((func_sel == `LSO_FUNC_LIMIT && pv_sel == `LSO_PV_OFF && q) [*3] |=> !switch_closed)
    else $error("limit with no variable conducts");
  // Main scenarios reached
  cover property (func_sel == `LSO_FUNC_LIMIT && switch_closed);
  cover property (alarm_active && switch_closed);
  cover property (invert && switch_closed);
endmodule
bind lso_switch lso_switch_properties u_props (
  .ref_clk(ref_clk),
  .rst(rst),
  .func_sel(func_sel),
  .pv_sel(pv_sel),
  .diag_cat(diag_cat),
  .alarm_active(alarm_active),
  .dout_src(dout_src),
  .adv_diag1_sw(adv_diag1_sw),
  .fail_mode(fail_mode),
  .invert(invert),
  .switch_closed(switch_closed),
  .switch_status(switch_status)
);

// ==== tb/lso_switch_tb.sv ====
// Testbench for the switch output decision logic
`timescale 1ns/1ps
`include "lso_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module lso_switch_tb;
  reg ref_clk = 0, rst = 1, alarm_active = 0, warning_active = 0, adv_diag1_sw = 0, adv_diag2_sw = 0, invert = 0;
  reg [2:0] func_sel = 0; reg [3:0] pv_sel = 0; reg [351:0] pv_values = 0;
  reg [31:0] thresh_on = 0, thresh_off = 0; reg [9:0] delay_on_ds = 0, delay_off_ds = 0;
  reg [1:0] diag_cat = 0, dout_src = 0, fail_mode = 1;
  wire switch_closed, switch_status, sensed;
  integer num_errors = 0, comparisons = 0;
  // Free-running 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  lso_switch #(.TICK_CYCLES(4)) u_dut (.ref_clk(ref_clk), .rst(rst), .func_sel(func_sel), .pv_sel(pv_sel),
    .pv_values(pv_values), .thresh_on(thresh_on), .thresh_off(thresh_off), .delay_on_ds(delay_on_ds),
    .delay_off_ds(delay_off_ds), .diag_cat(diag_cat), .alarm_active(alarm_active), .warning_active(warning_active),
    .dout_src(dout_src), .adv_diag1_sw(adv_diag1_sw), .adv_diag2_sw(adv_diag2_sw), .fail_mode(fail_mode),
    .invert(invert), .switch_closed(switch_closed), .switch_status(switch_status));
  lso_sense u_sense (.ref_clk(ref_clk), .rst(rst), .switch_closed(switch_closed), .sensed(sensed));
  // Wait edges, then step off the edge to sample
  task w(input integer n); begin repeat (n) @(posedge ref_clk); #1; end endtask
  // Output and status both compared
  task chk(input e); begin `CHK("switch_closed", e, switch_closed) `CHK("switch_status", e, switch_status) end endtask
  // New monitored value, then limit result
  task pv(input [31:0] v, input e); begin @(posedge ref_clk); pv_values[31:0] <= v; w(4); chk(e); end endtask
  task wrap_up; begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end endtask
  // =====================================================
  // Scenarios
  task t_modes; begin
    @(posedge ref_clk); func_sel <= `LSO_FUNC_ON; w(3); chk(1);
    `CHK("sensed", 1'b1, sensed)
    @(posedge ref_clk); invert <= 1; w(3); chk(0);
    @(posedge ref_clk); func_sel <= `LSO_FUNC_OFF; w(3); chk(1);
    @(posedge ref_clk); invert <= 0; w(3); chk(0);
  end endtask
  task t_lim; begin
    @(posedge ref_clk); func_sel <= `LSO_FUNC_LIMIT; pv_sel <= 1; thresh_on <= 32'h40000000; thresh_off <= 32'h3F800000;
    pv(32'h3FC00000, 0);
    pv(32'h40400000, 1);
    pv(32'h3FC00000, 1);
    pv(32'h3F000000, 0);
    @(posedge ref_clk); thresh_on <= 32'hBF800000; w(1);
    pv(32'hC0000000, 1);
    pv(32'hBF000000, 1);
    pv(32'h40000000, 0);
    pv(32'hC0000000, 1);
    // Negative switch-off threshold below the switch-on threshold
    @(posedge ref_clk); thresh_off <= 32'hC0400000; w(1);
    pv(32'hC0800000, 0);
    pv(32'hC0000000, 0);
    pv(32'hBF000000, 1);
    @(posedge ref_clk); pv_sel <= 0; w(4); chk(0);
  end endtask
  task t_delay; begin
    @(posedge ref_clk); thresh_on <= 32'h40000000; delay_on_ds <= 2; pv_values[31:0] <= 32'h40400000; pv_sel <= 1;
    w(5); chk(0);
    w(20); chk(1);
  end endtask
  task t_diag; begin
    @(posedge ref_clk); func_sel <= `LSO_FUNC_DIAG; warning_active <= 1; fail_mode <= `LSO_FAIL_ACTUAL; w(3); chk(1);
    @(posedge ref_clk); diag_cat <= `LSO_DIAG_WARN; w(3); chk(0);
    @(posedge ref_clk); diag_cat <= `LSO_DIAG_ALARM_WARN; warning_active <= 0; alarm_active <= 1; w(3); chk(0);
    @(posedge ref_clk); alarm_active <= 0; w(3); chk(1);
  end endtask
  task t_dout; begin
    @(posedge ref_clk); func_sel <= `LSO_FUNC_DOUT; dout_src <= `LSO_DSRC_AD1; adv_diag1_sw <= 1; w(3); chk(1);
    @(posedge ref_clk); dout_src <= `LSO_DSRC_AD2; w(3); chk(0);
    @(posedge ref_clk); adv_diag2_sw <= 1; adv_diag1_sw <= 0; w(3); chk(1);
    @(posedge ref_clk); dout_src <= `LSO_DSRC_OFF; w(3); chk(0);
  end endtask
  task t_fail; begin
    @(posedge ref_clk); func_sel <= `LSO_FUNC_ON; alarm_active <= 1; fail_mode <= `LSO_FAIL_OPEN; w(3); chk(0);
    @(posedge ref_clk); fail_mode <= `LSO_FAIL_ACTUAL; w(3); chk(1);
    @(posedge ref_clk); func_sel <= `LSO_FUNC_OFF; fail_mode <= `LSO_FAIL_CLOSED; w(3); chk(1);
    @(posedge ref_clk); invert <= 1; w(3); chk(0);
    @(posedge ref_clk); alarm_active <= 0; invert <= 0; w(3); chk(0);
  end endtask
  // Watchdog far beyond the expected run
  initial begin
    #100000;
    num_errors++;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    w(2); chk(0);
    t_modes; t_lim; t_delay; t_diag; t_dout; t_fail;
    wrap_up;
  end
endmodule
